// ### common/seq_pkg.sv
// Package: constants and types shared by the sequencer and the system end
package seq_pkg;
  // ==========================================
  // Clock division
  localparam int unsigned DIV_RATIO        = 4;       // Oscillator to bus clock ratio
  localparam logic [1:0]  DIV_LAST         = 2'h3;    // Last divider phase
  // ==========================================
  // Reset timing
  localparam int unsigned CLK_PERIOD_PS    = 5000;    // Reference period in ps
  localparam int unsigned POWERON_HOLD_MS  = 20;      // Least power-on reset time
  localparam int unsigned POWERON_HOLD_CYC =
    POWERON_HOLD_MS * (1000000000 / CLK_PERIOD_PS);  // Kept inside 32 bits
  localparam int unsigned RUN_RESET_TCYC   = 3;       // Least running reset, bus cycles
  localparam logic [1:0]  ADDR_HIGH_TCYC   = 2'h2;    // Bus cycles counted before lines go high
  localparam logic [1:0]  HOLD_TCYC        = 2'h3;    // Bus cycles the system end holds reset
  // ==========================================
  // Control register layout
  localparam logic [15:0] CTRL_ADDR        = 16'h0014;  // Control register address
  localparam int unsigned FIRST_EN_BIT     = 0;         // First external enable position
  localparam int unsigned SECOND_EN_BIT    = 1;         // Second external enable position
  localparam int unsigned RAM_EN_BIT       = 6;         // On-chip RAM enable position
  localparam logic [7:0]  CTRL_RESET       = 8'h7c;     // Value after reset
  // ==========================================
  // Vector addresses, high byte of each pair
  localparam logic [15:0] VEC_RESET   = 16'hfffe;
  localparam logic [15:0] VEC_TRAP    = 16'hffee;
  localparam logic [15:0] VEC_NMI     = 16'hfffc;
  localparam logic [15:0] VEC_SOFT    = 16'hfffa;
  localparam logic [15:0] VEC_FIRST   = 16'hfff8;
  localparam logic [15:0] VEC_CAPTURE = 16'hfff6;
  localparam logic [15:0] VEC_COMPARE = 16'hfff4;
  localparam logic [15:0] VEC_OVERFL  = 16'hfff2;
  localparam logic [15:0] VEC_MATCH   = 16'hffec;
  localparam logic [15:0] VEC_SECOND  = 16'hffea;
  localparam logic [15:0] VEC_SERIAL  = 16'hfff0;
  localparam logic [15:0] ADDR_ALL_HIGH = 16'hffff;     // Address lines during reset
  // ==========================================
  // Software register map of the system end
  localparam logic [3:0]  SYS_CMD     = 4'h0;  // Write: bit0 run reset, bit1 standby
  localparam logic [3:0]  SYS_PINS    = 4'h1;  // Write: request pin levels
  localparam logic [3:0]  SYS_STATUS  = 4'h2;  // Read/write one to clear: events
  localparam logic [3:0]  SYS_MASK    = 4'h3;  // Interrupt mask
  localparam logic [3:0]  SYS_VECTOR  = 4'h4;  // Not decoded: reads as zero
  localparam logic [3:0]  SYS_CTRLVAL = 4'h5;  // Not decoded: reads as zero
  localparam logic [7:0]  MASK_RESET  = 8'h00;
  // Sequencer states
  typedef enum logic [2:0] {
    ST_RESET, ST_FETCH_VEC, ST_RUN, ST_STACK, ST_VECTOR, ST_STANDBY
  } seq_state_t;
endpackage : seq_pkg

// ### common/seq_if.sv
// Interface: pins between the sequencer and the system logic
`timescale 1ns/1ps
interface seq_if;
  logic        reset_pin_n;        // Reset request, low active
  logic        standby_pin_n;      // Standby request, low active
  logic        nmi_pin_n;          // Non-maskable request, falling edge
  logic        ext_request_first;  // First external request, low active level
  logic        ext_request_second; // Second external request, low active level
  logic        mode_pin_zero;      // Mode strap zero
  logic        mode_pin_one;       // Mode strap one
  logic        bus_clock;          // Divided bus clock out
  logic [15:0] addr_bus;           // Address lines
  logic        osc_out_pin;        // Oscillator output, high in standby
  modport device (input reset_pin_n, standby_pin_n, nmi_pin_n, ext_request_first,
                  ext_request_second, mode_pin_zero, mode_pin_one,
                  output bus_clock, addr_bus, osc_out_pin);
  modport system (output reset_pin_n, standby_pin_n, nmi_pin_n, ext_request_first,
                  ext_request_second, mode_pin_zero, mode_pin_one,
                  input bus_clock, addr_bus, osc_out_pin);
endinterface : seq_if

// ### hw/seq_device.sv
// Device end: reset, standby and interrupt sequencing
//
// Added by the designer: the plain strobed port and the register addresses.
`timescale 1ns/1ps
// Notes on behaviour
// (RULE1) Bus clock is oscillator divided by four
// (RULE2) Standby low stops clock, holds reset
// (RULE3) Software clears RAM enable before standby
// (RULE4) Power-on reset held at least 20 ms
// (RULE5) Running reset held three bus cycles
// (RULE6) Third reset cycle drives address high
// (RULE7) Reset leaves working registers undefined
// (RULE8) Leave reset: straps, init, mask, vector
// (RULE9) Falling request edge starts non-maskable entry
// (RULE10) Non-maskable entry stacks, fetches FFFC
// (RULE11) Stack pointer set before edge request
// (RULE12) Maskable requests level, ignored when masked
// (RULE13) Maskable entry stacks, masks, fetches vector
// (RULE14) External requests gated by control bits
// (RULE15) Internal events merge into one request
// (RULE16) Priority order of vector pairs
// (RULE17) Second external then serial lowest
// (RULE18) Disabled enable blocks request and wake
module seq_device (
  input  wire logic ref_clk,             // Oscillator clock
  input  wire logic reset_n,             // Asynchronous reset
  seq_if.device     pins,                // System pins
  input  wire logic ctrl_we,             // Control register write
  input  wire logic [7:0] ctrl_wdata,    // Control register data
  input  wire logic mask_clear,          // Program clears interrupt mask
  input  wire logic instr_done,          // Current instruction finished
  input  wire logic software_request,    // Software interrupt
  input  wire logic trap_request,        // Trap request
  input  wire logic capture_event,       // Timer capture
  input  wire logic compare_event,       // Timer compare
  input  wire logic overflow_event,      // Timer overflow
  input  wire logic counter_match_event, // Timer match
  input  wire logic serial_event,        // Serial unit
  output logic      bus_tick,            // One-cycle bus clock enable
  output logic [15:0] vector_addr,       // Vector being fetched
  output logic      vector_fetch,        // Vector fetch pulse
  output logic      stack_push,          // Stacking in progress
  output logic      int_mask,            // Condition code mask bit
  output logic [7:0] ctrl_value,         // Control register image
  output logic [1:0] mode_latched,       // Latched mode straps
  output logic      wake_request         // Enabled external wake
);
  // ==========================================
  // Synchronisers
  logic [6:0] sync1_reg;  // First stage, read only by second
  logic [6:0] sync2_reg;  // Second stage
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      // Reset pin starts low, as the system holds it, so no false release
      sync1_reg <= 7'h3f;
      sync2_reg <= 7'h3f;
    end else begin
      sync1_reg <= {pins.reset_pin_n, pins.standby_pin_n, pins.nmi_pin_n,
                    pins.ext_request_first, pins.ext_request_second,
                    pins.mode_pin_zero, pins.mode_pin_one};
      sync2_reg <= sync1_reg;
    end
  end
  logic rst_s, standby_s, nmi_s, first_s, second_s, strap0_s, strap1_s;  // Synchronised pins
  assign {rst_s, standby_s, nmi_s, first_s, second_s, strap0_s, strap1_s} = sync2_reg;

  // ==========================================
  // State
  typedef struct packed {
    seq_pkg::seq_state_t state;
    logic [1:0]  div;        // Divider phase
    logic        tick;       // Bus clock enable
    logic        bclk;       // Bus clock pin
    logic [1:0]  rst_cnt;    // Bus cycles of reset seen
    logic [15:0] addr;       // Address lines
    logic        osc;        // Oscillator out
    logic        nmi_prev;   // Previous request level
    logic        nmi_pend;   // Latched edge
    logic        mask;       // Interrupt mask
    logic [7:0]  ctrl;       // Control register
    logic [1:0]  mode;       // Straps
    logic [15:0] vec;        // Selected vector
    logic        vfetch;     // Vector fetch pulse
    logic        push;       // Stacking
    logic        wake;       // Wake request
  } dev_state_t;
  dev_state_t cur_reg, cur_next;

  logic merged_req;  // Merged internal request
  logic first_ok;    // Gated first request
  logic second_ok;   // Gated second request
  assign merged_req = capture_event | compare_event | overflow_event |
                      counter_match_event | serial_event;  // [RULE15]
  assign first_ok  = !first_s && cur_reg.ctrl[seq_pkg::FIRST_EN_BIT];    // [RULE14] [RULE18]
  assign second_ok = !second_s && cur_reg.ctrl[seq_pkg::SECOND_EN_BIT];  // [RULE14] [RULE18]

  // Next state
  always_comb begin
    cur_next        = cur_reg;
    cur_next.tick   = 1'b0;
    cur_next.vfetch = 1'b0;
    cur_next.wake   = first_ok | second_ok;  // [RULE18]
    // Divide by four
    cur_next.div  = cur_reg.div + 2'h1;   // [RULE1]
    cur_next.tick = (cur_reg.div == seq_pkg::DIV_LAST);  // [RULE1]
    cur_next.bclk = cur_reg.div[1];       // [RULE1]
    cur_next.nmi_prev = nmi_s;
    if (cur_reg.nmi_prev && !nmi_s) begin
      cur_next.nmi_pend = 1'b1;           // [RULE9]
    end
    if (ctrl_we) begin
      cur_next.ctrl = ctrl_wdata;         // [RULE3]
    end
    if (mask_clear) begin
      cur_next.mask = 1'b0;
    end
    if (!standby_s) begin
      // Standby: clock stopped, reset held
      cur_next       = cur_reg;
      cur_next.state = seq_pkg::ST_STANDBY;  // [RULE2]
      cur_next.div   = 2'h0;
      cur_next.tick  = 1'b0;
      cur_next.bclk  = 1'b0;
      cur_next.osc   = 1'b1;
      cur_next.rst_cnt = 2'h0;
      cur_next.vfetch  = 1'b0;
      cur_next.push    = 1'b0;
      cur_next.wake    = 1'b0;
    end else if (!rst_s) begin
      // Reset: count bus cycles, then address high
      cur_next.state = seq_pkg::ST_RESET;
      cur_next.push  = 1'b0;
      cur_next.osc   = 1'b0;
      cur_next.ctrl  = {cur_reg.ctrl[7], seq_pkg::CTRL_RESET[6:0]};  // [RULE18]
      cur_next.nmi_pend = 1'b0;
      if (cur_reg.tick && cur_reg.rst_cnt != seq_pkg::HOLD_TCYC) begin
        cur_next.rst_cnt = cur_reg.rst_cnt + 2'h1;
      end
      if (cur_reg.rst_cnt >= seq_pkg::ADDR_HIGH_TCYC) begin
        cur_next.addr = seq_pkg::ADDR_ALL_HIGH;  // [RULE6]
      end
    end else begin
      unique case (cur_reg.state)
        seq_pkg::ST_STANDBY, seq_pkg::ST_RESET: begin
          // Release: latch straps, set mask, fetch reset vector
          cur_next.mode  = {strap1_s, strap0_s};  // [RULE8]
          cur_next.mask  = 1'b1;            // [RULE8]
          cur_next.vec   = seq_pkg::VEC_RESET;  // [RULE8]
          cur_next.rst_cnt = 2'h0;
          cur_next.state = seq_pkg::ST_FETCH_VEC;
        end
        seq_pkg::ST_FETCH_VEC: begin
          cur_next.vfetch = 1'b1;
          cur_next.addr   = cur_reg.vec;
          cur_next.state  = seq_pkg::ST_RUN;
        end
        seq_pkg::ST_RUN: begin
          // Fixed priority, taken only at instruction end [RULE16] [RULE17]
          if (instr_done) begin
            cur_next.state = seq_pkg::ST_STACK;
            if (trap_request) begin
              cur_next.vec = seq_pkg::VEC_TRAP;
            end else if (cur_reg.nmi_pend) begin
              cur_next.vec = seq_pkg::VEC_NMI;      // [RULE9] [RULE10]
              // A fresh edge in this cycle stays pending
              cur_next.nmi_pend = cur_reg.nmi_prev && !nmi_s;
            end else if (software_request) begin
              cur_next.vec = seq_pkg::VEC_SOFT;
            end else if (!cur_reg.mask && first_ok) begin
              cur_next.vec = seq_pkg::VEC_FIRST;    // [RULE12]
            end else if (!cur_reg.mask && merged_req && capture_event) begin
              cur_next.vec = seq_pkg::VEC_CAPTURE;
            end else if (!cur_reg.mask && merged_req && compare_event) begin
              cur_next.vec = seq_pkg::VEC_COMPARE;
            end else if (!cur_reg.mask && merged_req && overflow_event) begin
              cur_next.vec = seq_pkg::VEC_OVERFL;
            end else if (!cur_reg.mask && merged_req && counter_match_event) begin
              cur_next.vec = seq_pkg::VEC_MATCH;
            end else if (!cur_reg.mask && second_ok) begin
              cur_next.vec = seq_pkg::VEC_SECOND;
            end else if (!cur_reg.mask && merged_req) begin
              cur_next.vec = seq_pkg::VEC_SERIAL;
            end else begin
              cur_next.state = seq_pkg::ST_RUN;     // [RULE12] masked: ignore
            end
            if (cur_next.state == seq_pkg::ST_STACK) begin
              cur_next.push = 1'b1;                 // [RULE10] [RULE13]
            end
          end
        end
        seq_pkg::ST_STACK: begin
          // Registers pushed, then mask set
          cur_next.push  = 1'b0;
          cur_next.mask  = 1'b1;                    // [RULE13]
          cur_next.state = seq_pkg::ST_VECTOR;
        end
        seq_pkg::ST_VECTOR: begin
          // Final cycle fetches vector
          cur_next.vfetch = 1'b1;                   // [RULE13]
          cur_next.addr   = cur_reg.vec;
          cur_next.state  = seq_pkg::ST_RUN;
        end
      endcase
    end
  end

  // Register update; working registers are not part of this state [RULE7]
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      cur_reg <= '{state: seq_pkg::ST_RESET, div: 2'h0, tick: 1'b0, bclk: 1'b0,
                   rst_cnt: 2'h0, addr: 16'h0000, osc: 1'b0, nmi_prev: 1'b1,
                   nmi_pend: 1'b0, mask: 1'b1, ctrl: seq_pkg::CTRL_RESET,
                   mode: 2'h0, vec: seq_pkg::VEC_RESET, vfetch: 1'b0,
                   push: 1'b0, wake: 1'b0};
    end else begin
      cur_reg <= cur_next;
    end
  end

  // Outputs
  assign pins.bus_clock   = cur_reg.bclk;
  assign pins.addr_bus    = cur_reg.addr;
  assign pins.osc_out_pin = cur_reg.osc;
  assign bus_tick     = cur_reg.tick;
  assign vector_addr  = cur_reg.vec;
  assign vector_fetch = cur_reg.vfetch;
  assign stack_push   = cur_reg.push;
  assign int_mask     = cur_reg.mask;
  assign ctrl_value   = cur_reg.ctrl;
  assign mode_latched = cur_reg.mode;
  assign wake_request = cur_reg.wake;
endmodule // seq_device

// ### hw/seq_system.sv
// System end: drives reset, standby and request pins
`timescale 1ns/1ps
module seq_system #(
  parameter int unsigned POWERON_CYC = seq_pkg::POWERON_HOLD_CYC  // Power-on hold
) (
  input  wire logic ref_clk,        // Clock
  input  wire logic reset_n,        // Asynchronous reset
  seq_if.system     pins,           // Device pins
  input  wire logic [3:0] addr,     // Register address
  input  wire logic [7:0] wdata,    // Write data
  input  wire logic wr,             // Write strobe
  input  wire logic rd,             // Read strobe
  output logic [7:0] rdata,         // Read data, one cycle later
  output logic      irq             // Interrupt level
);
  // ==========================================
  // Synchronisers for device outputs
  logic [1:0] s1_reg;  // First stage
  logic [1:0] s2_reg;  // Second stage
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      s1_reg <= 2'h0;
      s2_reg <= 2'h0;
    end else begin
      s1_reg <= {pins.bus_clock, pins.osc_out_pin};
      s2_reg <= s1_reg;
    end
  end
  // ==========================================
  // State
  typedef struct packed {
    logic [31:0] por_cnt;   // Power-on counter
    logic [1:0]  run_cnt;   // Bus cycles of running reset
    logic        run_rst;   // Running reset active
    logic        rst_pin;   // Reset pin level
    logic        standby_lvl; // Standby pin level
    logic [2:0]  req;       // nmi, first, second levels
    logic        bclk_prev; // Previous bus clock
    logic [7:0]  status;    // Events
    logic [7:0]  mask;      // Interrupt mask
    logic [7:0]  rdata;     // Read data
    logic        irq;       // Interrupt
  } sys_state_t;
  sys_state_t cur_reg, cur_next;
  logic [7:0] ev;  // Events this cycle; bit 2 is the standby level, not a pulse

  always_comb begin
    cur_next = cur_reg;
    ev = 8'h00;
    cur_next.bclk_prev = s2_reg[1];
    // Power-on hold
    if (cur_reg.por_cnt < POWERON_CYC) begin
      cur_next.por_cnt = cur_reg.por_cnt + 32'h1;  // [RULE4]
    end else if (!cur_reg.rst_pin && !cur_reg.run_rst) begin
      cur_next.rst_pin = 1'b1;
      ev[0] = 1'b1;
    end
    // Running reset of three bus cycles
    if (cur_reg.run_rst && s2_reg[1] && !cur_reg.bclk_prev) begin
      if (cur_reg.run_cnt == seq_pkg::HOLD_TCYC) begin
        cur_next.run_rst = 1'b0;                   // [RULE5]
        cur_next.rst_pin = 1'b1;
        ev[1] = 1'b1;
      end else begin
        cur_next.run_cnt = cur_reg.run_cnt + 2'h1; // [RULE5]
      end
    end
    if (wr && addr == seq_pkg::SYS_CMD) begin
      if (wdata[0]) begin
        cur_next.run_rst = 1'b1;
        cur_next.run_cnt = 2'h0;
        cur_next.rst_pin = 1'b0;
      end
      cur_next.standby_lvl = !wdata[1];  // Standby request, low active
    end
    if (wr && addr == seq_pkg::SYS_PINS) begin
      cur_next.req = wdata[2:0];      // [RULE11] stack set before edge
    end
    if (wr && addr == seq_pkg::SYS_MASK) begin
      cur_next.mask = wdata;
    end
    ev[2] = s2_reg[0];                // Device in standby
    cur_next.status = cur_reg.status;
    if (wr && addr == seq_pkg::SYS_STATUS) begin
      cur_next.status = cur_reg.status & ~wdata;
    end
    cur_next.status = cur_next.status | ev;  // Set wins over clear
    cur_next.rdata = 8'h00;
    if (rd) begin
      unique case (addr)
        seq_pkg::SYS_STATUS: cur_next.rdata = cur_reg.status;
        seq_pkg::SYS_MASK:   cur_next.rdata = cur_reg.mask;
        seq_pkg::SYS_PINS:   cur_next.rdata = {5'h00, cur_reg.req};
        seq_pkg::SYS_CMD:    cur_next.rdata = {6'h00, !cur_reg.standby_lvl, cur_reg.run_rst};
        default:             cur_next.rdata = 8'h00;
      endcase
    end
    cur_next.irq = |(cur_next.status & cur_next.mask);
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      cur_reg <= '{por_cnt: 32'h0, run_cnt: 2'h0, run_rst: 1'b0, rst_pin: 1'b0,
                   standby_lvl: 1'b1, req: 3'h7, bclk_prev: 1'b0, status: 8'h00,
                   mask: seq_pkg::MASK_RESET, rdata: 8'h00, irq: 1'b0};
    end else begin
      cur_reg <= cur_next;
    end
  end

  assign pins.reset_pin_n        = cur_reg.rst_pin;
  assign pins.standby_pin_n      = cur_reg.standby_lvl;
  assign pins.nmi_pin_n          = cur_reg.req[2];
  assign pins.ext_request_first  = cur_reg.req[1];
  assign pins.ext_request_second = cur_reg.req[0];
  assign pins.mode_pin_zero      = 1'b1;
  assign pins.mode_pin_one       = 1'b0;
  assign rdata = cur_reg.rdata;
  assign irq   = cur_reg.irq;
endmodule // seq_system

// ### testbench/seq_asserts.sv
// Checker: relations on the pins between the system end and the device end
`timescale 1ns/1ps
module seq_asserts #(
  parameter int unsigned POWERON_CYC = seq_pkg::POWERON_HOLD_CYC  // Power-on hold in cycles
) (
  input wire logic        ref_clk,
  input wire logic        reset_n,
  input wire logic        reset_pin_n,
  input wire logic        standby_pin_n,
  input wire logic        bus_clock,
  input wire logic [15:0] addr_bus,
  input wire logic        osc_out_pin
);
  // ==========================================
  // Helper logic
  logic [31:0] low_cnt;   // Cycles the reset pin has stayed low
  logic        pon_done;  // First release already seen
  // Count low cycles and mark the power-on release
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      low_cnt  <= '0;
      pon_done <= 1'b0;
    end else begin
      low_cnt  <= reset_pin_n ? 32'h0 : low_cnt + 32'h1;
      pon_done <= pon_done | reset_pin_n;
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  // ==========================================
  // Sequences
  sequence high_half; bus_clock [*2]; endsequence
  sequence low_half; !bus_clock [*2]; endsequence
  sequence went_low; $fell(reset_pin_n); endsequence
  // ==========================================
  // Assertions
  a_clock_quarter: assert property (
    disable iff (!reset_n || !standby_pin_n)
    $rose(bus_clock) |-> high_half ##1 low_half ##1 bus_clock)
    else $error("bus clock is not a quarter of the reference");
  a_clock_frozen: assert property (!standby_pin_n [*5] |-> $stable(bus_clock))
    else $error("bus clock runs in standby");
  a_osc_parked: assert property (!standby_pin_n [*5] |-> osc_out_pin)
    else $error("oscillator output not high in standby");
  a_poweron_hold: assert property (
    $rose(reset_pin_n) && !pon_done |-> low_cnt + 32'h1 >= POWERON_CYC)
    else $error("power-on reset released early");
  a_run_hold: assert property (
    $rose(reset_pin_n) |-> low_cnt >= seq_pkg::RUN_RESET_TCYC * seq_pkg::DIV_RATIO)
    else $error("running reset shorter than three bus cycles");
  a_addr_late: assert property (
    went_low and addr_bus != seq_pkg::ADDR_ALL_HIGH |-> ##1
    (addr_bus != seq_pkg::ADDR_ALL_HIGH) [*3])
    else $error("address lines high too early in reset");
  a_addr_high: assert property (
    went_low |-> ##[4:16] addr_bus == seq_pkg::ADDR_ALL_HIGH)
    else $error("address lines not high in reset");
  a_addr_kept: assert property (
    addr_bus == seq_pkg::ADDR_ALL_HIGH && !reset_pin_n |=> addr_bus == seq_pkg::ADDR_ALL_HIGH)
    else $error("address lines dropped during reset");
  a_reset_vector: assert property (
    $rose(reset_pin_n) |-> ##[2:12] addr_bus == seq_pkg::VEC_RESET)
    else $error("reset vector not fetched after release");
endmodule // seq_asserts

// ### testbench/mpu_reset_standby_interrupt_sequencer_tb_top.sv
// Testbench: both ends joined over the pin interface
`timescale 1ns/1ps
module mpu_reset_standby_interrupt_sequencer_tb_top;
  localparam int unsigned PON = 20;  // Shortened power-on hold
  // Vectors in priority order
  localparam logic [15:0] VTAB [0:9] = '{seq_pkg::VEC_TRAP, seq_pkg::VEC_NMI,
    seq_pkg::VEC_SOFT, seq_pkg::VEC_FIRST, seq_pkg::VEC_CAPTURE, seq_pkg::VEC_COMPARE,
    seq_pkg::VEC_OVERFL, seq_pkg::VEC_MATCH, seq_pkg::VEC_SECOND, seq_pkg::VEC_SERIAL};
  logic        ref_clk, reset_n;                 // Clock and reset
  logic        ctrl_we, mask_clear, instr_done;  // Device controls
  logic [7:0]  ctrl_wdata, ctrl_value;           // Control image
  logic [9:0]  src;                              // Requests, priority order
  logic [3:0]  addr;                             // Register address
  logic [7:0]  wdata, rdata;                     // Register data
  logic        wr, rd, irq;                      // Strobes, interrupt
  logic [15:0] vector_addr;                      // Fetched vector
  logic        vector_fetch, int_mask, wake_request, stack_push;
  logic [1:0]  mode_latched;                     // Latched straps
  logic [15:0] exp_q [$];                        // Expected vectors
  int          err_count = 0, n_compared = 0, cycles = 0, n_push = 0;
  seq_if link ();                                // Pins between ends
  seq_device seq_device_i (.ref_clk, .reset_n, .pins(link.device), .ctrl_we, .ctrl_wdata,
    .mask_clear, .instr_done, .software_request(src[2]), .trap_request(src[0]),
    .capture_event(src[4]), .compare_event(src[5]), .overflow_event(src[6]),
    .counter_match_event(src[7]), .serial_event(src[9]), .bus_tick(), .vector_addr,
    .vector_fetch, .stack_push, .int_mask, .ctrl_value, .mode_latched, .wake_request);
  seq_system #(.POWERON_CYC(PON)) seq_system_i (.ref_clk, .reset_n, .pins(link.system),
    .addr, .wdata, .wr, .rd, .rdata, .irq);
  seq_asserts #(.POWERON_CYC(PON)) seq_asserts_i (.ref_clk, .reset_n,
    .reset_pin_n(link.reset_pin_n), .standby_pin_n(link.standby_pin_n),
    .bus_clock(link.bus_clock), .addr_bus(link.addr_bus), .osc_out_pin(link.osc_out_pin));
  // ==========================================
  // Clock
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  // ==========================================
  // Shared tasks
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic conclude();
    chk("pending fetches", 16'(exp_q.size()), 16'h0);
    chk("stack pushes", 16'(n_push), 16'h000b);
    if (err_count == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // One-cycle register write
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge ref_clk);
    wr <= 1'b0;
  endtask
  // Read, data checked in the following cycle
  task automatic rd_reg(input logic [3:0] a, input logic [7:0] e, input string nm);
    @(posedge ref_clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge ref_clk);
    rd <= 1'b0;
    @(negedge ref_clk);
    chk(nm, {8'h0, rdata}, {8'h0, e});
  endtask
  // Control register write and readback
  task automatic ctrl(input logic [7:0] d);
    @(posedge ref_clk);
    ctrl_we    <= 1'b1;
    ctrl_wdata <= d;
    @(posedge ref_clk);
    ctrl_we <= 1'b0;
    @(negedge ref_clk);
    chk("control", {8'h0, ctrl_value}, {8'h0, d});
  endtask
  // Raise requests, end an instruction, note the expected vector
  task automatic take(input logic [9:0] s, input logic [15:0] v, input bit hit, input bit clr);
    @(posedge ref_clk);
    mask_clear <= clr;
    src        <= s;
    @(posedge ref_clk);
    mask_clear <= 1'b0;
    wr_reg(seq_pkg::SYS_PINS, {5'h0, ~s[1], ~s[3], ~s[8]});
    repeat (6) @(posedge ref_clk);
    if (hit) exp_q.push_back(v);
    instr_done <= 1'b1;
    @(posedge ref_clk);
    instr_done <= 1'b0;
    repeat (8) @(posedge ref_clk);
    src <= '0;
    wr_reg(seq_pkg::SYS_PINS, 8'h07);
    repeat (6) @(posedge ref_clk);
  endtask
  // ==========================================
  // Watcher: every fetch consumes the oldest note; hang guard
  always @(posedge ref_clk) begin
    cycles++;
    if (stack_push === 1'b1) n_push++;
    if (vector_fetch === 1'b1) begin
      if (exp_q.size() == 0) chk("unexpected fetch", vector_addr, 16'h0);
      else chk("vector", vector_addr, exp_q.pop_front());
    end
    if (cycles == 4000) begin
      err_count++;
      conclude();
    end
  end
  // ==========================================
  // Main sequence
  initial begin
    logic [31:0] rnd;
    logic [9:0]  s;
    rnd = $urandom(48263);
    {reset_n, ctrl_we, mask_clear, instr_done, wr, rd} = '0;
    {ctrl_wdata, wdata, addr, src} = '0;
    exp_q.push_back(seq_pkg::VEC_RESET);
    repeat (5) @(posedge ref_clk);
    reset_n <= 1'b1;
    repeat (PON + 30) @(negedge ref_clk);
    chk("mode straps", {14'h0, mode_latched}, 16'h0001);
    chk("mask", {15'h0, int_mask}, 16'h0001);
    chk("control", {8'h0, ctrl_value}, {8'h0, seq_pkg::CTRL_RESET});
    chk("wake", {15'h0, wake_request}, 16'h0);
    take(10'h010, 16'h0, 1'b0, 1'b0);
    take(10'h010, seq_pkg::VEC_CAPTURE, 1'b1, 1'b1);
    chk("mask", {15'h0, int_mask}, 16'h0001);
    ctrl(8'h40);
    take(10'h008, 16'h0, 1'b0, 1'b1);
    take(10'h100, 16'h0, 1'b0, 1'b1);
    ctrl(8'h43);
    // Each source against random lower-priority company
    for (int i = 0; i < 10; i++) begin
      rnd = $urandom;
      s = rnd[9:0] & (10'h3ff << (i + 1));
      s[i] = 1'b1;
      if (i != 1) s[1] = 1'b0;
      take(s, VTAB[i], 1'b1, 1'b1);
    end
    wr_reg(seq_pkg::SYS_MASK, 8'h00);
    wr_reg(seq_pkg::SYS_STATUS, 8'h07);
    exp_q.push_back(seq_pkg::VEC_RESET);
    wr_reg(seq_pkg::SYS_CMD, 8'h01);
    repeat (40) @(negedge ref_clk);
    chk("control", {8'h0, ctrl_value}, {8'h0, seq_pkg::CTRL_RESET});
    chk("mask", {15'h0, int_mask}, 16'h0001);
    rd_reg(seq_pkg::SYS_STATUS, 8'h02, "status");
    chk("irq", {15'h0, irq}, 16'h0);
    wr_reg(seq_pkg::SYS_MASK, 8'h02);
    repeat (2) @(negedge ref_clk);
    chk("irq", {15'h0, irq}, 16'h0001);
    wr_reg(seq_pkg::SYS_STATUS, 8'h02);
    repeat (2) @(negedge ref_clk);
    chk("irq", {15'h0, irq}, 16'h0);
    rd_reg(4'hf, 8'h00, "unmapped");
    ctrl(8'h3c);
    wr_reg(seq_pkg::SYS_CMD, 8'h02);
    repeat (12) @(negedge ref_clk);
    chk("osc out", {15'h0, link.osc_out_pin}, 16'h0001);
    rd_reg(seq_pkg::SYS_STATUS, 8'h04, "standby status");
    conclude();
  end
endmodule // mpu_reset_standby_interrupt_sequencer_tb_top
